/* src/tos_pkg.sv */
// tos_pkg: constants shared by the timed output scheduler files
// assumes one 250 MHz clock and entry-serial writes of the output image
package tos_pkg;
    // fixed process image lengths in bytes
    localparam logic [7:0] IN_LEN_RESET = 8'h04;
    localparam logic [7:0] OUT_LEN_SHORT = 8'h14;
    localparam logic [7:0] OUT_LEN_LONG = 8'h3c;
    // entry layout: state byte, sequence byte, 16-bit microsecond time
    localparam int ENTRY_WIDTH = 32;
    localparam int STATE_POS = 24;
    localparam int SEQ_POS = 16;
    localparam int TIME_POS = 0;
    // state byte fields
    localparam int LVL0_BIT = 7;
    localparam int LVL1_BIT = 6;
    localparam int EN0_BIT = 5;
    localparam int EN1_BIT = 4;
    // sequence byte fields
    localparam int SEQ_LAST_BIT = 6;
    localparam logic [7:0] SEQ_DUE_MARK = 8'h80;
    // queue depth and count width
    localparam int QUEUE_DEPTH = 32;
    localparam int COUNT_WIDTH = 6;
    // queue status fields
    localparam int QST_FULL_BIT = 0;
    localparam int QST_RUN_BIT = 1;
    localparam int QST_END_BIT = 7;
    // reset values of the status bytes
    localparam logic [7:0] LAST_SEQ_RESET = 8'h00;
    localparam logic [7:0] NEXT_SEQ_RESET = 8'h80;
    localparam logic [7:0] QSTAT_RESET = 8'h00;
endpackage

/* src/tos_queue.sv */
// tos_queue: first-in first-out store for schedule entries
// assumes a single clock; the reader pops only while out_valid is high
`timescale 1ns/100ps
`default_nettype none
module tos_queue #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // entry storage
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    logic [CW-1:0] cnt_q; // entries held
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    // an empty queue shows an all-zero head, never stale data
    assign out_data = out_valid ? mem[rd_q] : '0;
    assign count = cnt_q;

    // storage write; popped slots are not cleared, the mux above hides them
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            // push and pop together leave the level unchanged
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // tos_queue
`default_nettype wire

/* src/tos_scheduler.sv */
// tos_scheduler: time-stamped two-channel output scheduler
// assumes entries arrive one per cycle from the output image port and
// the head module's microsecond ticker is synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module tos_scheduler #(
    parameter bit WIDE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic entry_wr_valid,
    input wire logic [7:0] entry_wr_state,
    input wire logic [7:0] entry_wr_seq,
    input wire logic [15:0] entry_wr_time,
    output logic entry_wr_ready,
    input wire logic [15:0] us_ticker,
    output logic [1:0] out_level,
    output logic [1:0] out_enable,
    output logic [1:0] out_pin,
    output logic [7:0] last_accepted_sequence,
    output logic [7:0] next_due_sequence,
    output logic [7:0] queue_status,
    output logic [7:0] queued_entry_count,
    output logic [7:0] input_image_length,
    output logic [7:0] output_image_length
);
    // fixed length variant, chosen at build time
    localparam logic [7:0] OUT_LEN =
        WIDE_VARIANT ? tos_pkg::OUT_LEN_LONG : tos_pkg::OUT_LEN_SHORT;

    // field extraction, used on the head side only
    function automatic logic [7:0] f_state(input logic [31:0] e);
        f_state = e[tos_pkg::STATE_POS +: 8];
    endfunction
    function automatic logic [7:0] f_seq(input logic [31:0] e);
        f_seq = e[tos_pkg::SEQ_POS +: 8];
    endfunction
    function automatic logic [15:0] f_time(input logic [31:0] e);
        f_time = e[tos_pkg::TIME_POS +: 16];
    endfunction

    // queue side signals
    logic head_valid; // an entry is pending
    logic [31:0] head_data; // oldest pending entry, zero when empty
    logic [5:0] qcount; // entries pending
    logic q_ready; // room for one more entry
    logic head_pop; // head leaves the queue this cycle

    // registered state
    logic [7:0] state_q; // applied state byte
    logic [7:0] last_seq_q; // last accepted sequence byte
    // sequence bytes mirrored beside the queue, so the entry behind the
    // head is known in the cycle the head leaves
    logic [7:0] seq_mem [tos_pkg::QUEUE_DEPTH]; // mirrored sequence bytes
    logic [4:0] seq_wr_q; // mirror write pointer
    logic [4:0] seq_rd_q; // mirror read pointer, tracks the queue head
    wire [4:0] seq_rd_nx = seq_rd_q + 5'h01; // slot behind the head
    logic [7:0] next_seq_q;
    logic [7:0] qstat_q;
    logic [7:0] qcnt_q;
    logic rdy_q;
    logic [7:0] state_d;
    logic [7:0] next_seq_d;
    logic [7:0] qstat_d;

    // entry packed as state, sequence, time
    wire [31:0] wr_entry = {entry_wr_state, entry_wr_seq, entry_wr_time};
    // accept uses the registered ready the controller sees
    wire accept = entry_wr_valid && rdy_q;

    // queue of 32 entries keeps order and hides empty slots as zero
    tos_queue #(
        .WIDTH(tos_pkg::ENTRY_WIDTH),
        .DEPTH(tos_pkg::QUEUE_DEPTH),
        .CW(tos_pkg::COUNT_WIDTH)
    ) u_queue (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(accept),
        .in_ready(q_ready),
        .in_data(wr_entry),
        .out_valid(head_valid),
        .out_ready(head_pop),
        .out_data(head_data),
        .count(qcount)
    );

    // wrap-safe "ticker has reached due time": difference below half range
    wire [15:0] since_due = us_ticker - f_time(head_data);
    wire head_due = head_valid && !since_due[15];
    // only the head may run, so entries issue strictly in order
    assign head_pop = head_due;

    // ready one cycle ahead: a write in flight may take the last slot
    wire rdy_d = (qcount < 6'(tos_pkg::QUEUE_DEPTH - 1)) ||
        (qcount == 6'(tos_pkg::QUEUE_DEPTH - 1) && !accept) ||
        head_pop;

    // applied state: take the due head's level and enable bits
    assign state_d = head_due ? f_state(head_data) : state_q;

    // entry that becomes the head once the current head leaves
    wire [7:0] behind_seq = (qcount > 6'h01) ? seq_mem[seq_rd_nx] :
        accept ? entry_wr_seq : 8'(f_seq(head_data) + 8'h01);

    // next due: pending head marked; once empty, the one after the last
    // run; a write into an empty queue shows at once
    assign next_seq_d = head_due ? (behind_seq | tos_pkg::SEQ_DUE_MARK) :
        head_valid ? (f_seq(head_data) | tos_pkg::SEQ_DUE_MARK) :
        accept ? (entry_wr_seq | tos_pkg::SEQ_DUE_MARK) :
        next_seq_q;

    // queue status: batch end seen, running, full
    always_comb begin
        qstat_d = qstat_q;
        // a new batch starting clears the end mark, unless it ends itself
        if (accept) begin
            qstat_d[tos_pkg::QST_END_BIT] = entry_wr_seq[tos_pkg::SEQ_LAST_BIT];
        end
        // running: some entry has been issued, whatever its enables; never cleared
        if (head_due) begin
            qstat_d[tos_pkg::QST_RUN_BIT] = 1'b1;
        end
        qstat_d[tos_pkg::QST_FULL_BIT] = !q_ready;
    end

    // output state and its pin drive
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= '0;
            out_level <= '0;
            out_enable <= '0;
            out_pin <= '0;
        end else begin
            state_q <= state_d;
            out_level <= {state_d[tos_pkg::LVL1_BIT],
                state_d[tos_pkg::LVL0_BIT]};
            out_enable <= {state_d[tos_pkg::EN1_BIT],
                state_d[tos_pkg::EN0_BIT]};
            // a channel drives only once enabled by some entry
            out_pin[0] <= state_d[tos_pkg::LVL0_BIT] &
                state_d[tos_pkg::EN0_BIT];
            out_pin[1] <= state_d[tos_pkg::LVL1_BIT] &
                state_d[tos_pkg::EN1_BIT];
        end
    end

    // mirror storage write, same slot order as the queue
    always_ff @(posedge sys_clk) begin
        if (accept) begin
            seq_mem[seq_wr_q] <= entry_wr_seq;
        end
    end

    // sequence bookkeeping
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_seq_q <= tos_pkg::LAST_SEQ_RESET;
            seq_wr_q <= '0;
            seq_rd_q <= '0;
            next_seq_q <= tos_pkg::NEXT_SEQ_RESET;
        end else begin
            if (accept) begin
                last_seq_q <= entry_wr_seq;
                seq_wr_q <= seq_wr_q + 5'h01;
            end
            // mirror head follows the queue head, one step per run
            if (head_pop) begin
                seq_rd_q <= seq_rd_q + 5'h01;
            end
            next_seq_q <= next_seq_d;
        end
    end

    // status, count and ready registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            qstat_q <= tos_pkg::QSTAT_RESET;
            qcnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            qstat_q <= qstat_d;
            // count follows the queue, dropping as each entry runs
            qcnt_q <= 8'(qcount) + 8'(accept) - 8'(head_pop);
            rdy_q <= rdy_d;
        end
    end

    // fixed length parameters, not writable by the controller
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            input_image_length <= tos_pkg::IN_LEN_RESET;
            output_image_length <= OUT_LEN;
        end else begin
            input_image_length <= tos_pkg::IN_LEN_RESET;
            output_image_length <= OUT_LEN;
        end
    end

    // status bytes of the input image come straight from flops
    assign last_accepted_sequence = last_seq_q;
    assign next_due_sequence = next_seq_q;
    assign queue_status = qstat_q;
    assign queued_entry_count = qcnt_q;
    assign entry_wr_ready = rdy_q;
endmodule // tos_scheduler
`default_nettype wire

/* tb/tos_scheduler_checker.sv */
// tos_scheduler_checker: port assertions for the scheduler
// assumes sys_clk rising edge and synchronous active-high rst
`timescale 1ns/100ps
`default_nettype none
module tos_scheduler_checker #(
    parameter bit WIDE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic entry_wr_valid,
    input wire logic entry_wr_ready,
    input wire logic [7:0] entry_wr_seq,
    input wire logic [1:0] out_level,
    input wire logic [1:0] out_enable,
    input wire logic [1:0] out_pin,
    input wire logic [7:0] last_accepted_sequence,
    input wire logic [7:0] next_due_sequence,
    input wire logic [7:0] queued_entry_count,
    input wire logic [7:0] input_image_length,
    input wire logic [7:0] output_image_length
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    in_len_a: assert property (input_image_length == 8'h04)
        else $error("input length wrong");
    out_len_a: assert property (output_image_length ==
        (WIDE_VARIANT ? 8'h3c : 8'h14)) else $error("output length wrong");
    pin_drive_a: assert property (out_pin == (out_level & out_enable))
        else $error("pin not level and enable");
    take_seq_a: assert property (entry_wr_valid && entry_wr_ready |=>
        last_accepted_sequence == $past(entry_wr_seq)) else $error("seq lost");
    refuse_a: assert property (!entry_wr_ready |=>
        $stable(last_accepted_sequence)) else $error("refused entry taken");
    count_max_a: assert property (queued_entry_count <= 8'h20)
        else $error("count above depth");
    due_mark_a: assert property (next_due_sequence[7])
        else $error("next due unmarked");
    empty_hold_a: assert property (queued_entry_count == 8'h00 |=>
        $stable(out_level) && $stable(out_enable)) else $error("ran empty");
endmodule // tos_scheduler_checker
bind tos_scheduler tos_scheduler_checker #(.WIDE_VARIANT(WIDE_VARIANT)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .entry_wr_valid(entry_wr_valid),
    .entry_wr_ready(entry_wr_ready), .entry_wr_seq(entry_wr_seq),
    .out_level(out_level), .out_enable(out_enable), .out_pin(out_pin),
    .last_accepted_sequence(last_accepted_sequence),
    .next_due_sequence(next_due_sequence),
    .queued_entry_count(queued_entry_count),
    .input_image_length(input_image_length),
    .output_image_length(output_image_length));
`default_nettype wire

/* tb/tos_scheduler_test.sv */
// tos_scheduler_test: self-checking bench for the scheduler
// assumes tos_ticker as head module ticker; results checked from a queue
`timescale 1ns/100ps
`default_nettype none
module tos_scheduler_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hold = 1'b1; // frozen ticker keeps entries pending
    logic wv = 1'b0;
    logic [7:0] ws = 8'h00;
    logic [7:0] wq = 8'h00;
    logic [15:0] wt = 16'h0000;
    logic rdy;
    logic [15:0] tick;
    logic [1:0] lvl, ena, pin;
    logic [7:0] last, nxt, qst, cnt, ilen, olen;
    logic [7:0] olen_w; // length seen on the wide variant
    logic [7:0] prv = 8'h00; // count at the previous edge
    logic [15:0] wl[$]; // written {state, seq} not yet planned
    logic [11:0] exp_q[$]; // {next due, level, enable} per run
    logic [11:0] e;
    logic [7:0] bs[5] = '{8'h30, 8'hb0, 8'hf0, 8'h30, 8'h70};
    int n_mismatch = 0;
    int n_tests = 0;
    always #2 sys_clk = ~sys_clk;
    tos_ticker #(.DIV(2)) u_tick (.sys_clk(sys_clk), .rst(rst), .hold(hold),
        .us_ticker(tick));
    tos_scheduler DUT (.sys_clk(sys_clk), .rst(rst), .entry_wr_valid(wv),
        .entry_wr_state(ws), .entry_wr_seq(wq), .entry_wr_time(wt),
        .entry_wr_ready(rdy), .us_ticker(tick), .out_level(lvl),
        .out_enable(ena), .out_pin(pin), .last_accepted_sequence(last),
        .next_due_sequence(nxt), .queue_status(qst),
        .queued_entry_count(cnt), .input_image_length(ilen),
        .output_image_length(olen));
    // wide variant built beside it; only its fixed length is compared
    tos_scheduler #(.WIDE_VARIANT(1'b1)) wide_dut (.sys_clk(sys_clk),
        .rst(rst), .entry_wr_valid(wv), .entry_wr_state(ws),
        .entry_wr_seq(wq), .entry_wr_time(wt), .entry_wr_ready(),
        .us_ticker(tick), .out_level(), .out_enable(), .out_pin(),
        .last_accepted_sequence(), .next_due_sequence(), .queue_status(),
        .queued_entry_count(), .input_image_length(),
        .output_image_length(olen_w));
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] a, input logic [7:0] b, input string m);
        n_tests++;
        if (a !== b) begin
            n_mismatch++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask
    // offer one entry, held until an edge samples ready high
    task wr(input logic [7:0] s, input logic [7:0] q, input logic [15:0] t);
        int i;
        wv <= 1'b1;
        ws <= s;
        wq <= q;
        wt <= t;
        wl.push_back({s, q});
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if (rdy === 1'b1) break;
        end
        if (i == 40) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask
    // turn written entries into run notes in queue order
    task plan;
        logic [7:0] nx;
        while (wl.size() > 0) begin
            nx = (wl.size() > 1) ? wl[1][7:0] : wl[0][7:0] + 8'h01;
            exp_q.push_back({nx | 8'h80, wl[0][14], wl[0][15], wl[0][12],
                wl[0][13]});
            void'(wl.pop_front());
        end
    endtask
    // let time run until the queue empties, bounded
    task drain;
        int i;
        hold <= 1'b0;
        for (i = 0; i < 3000 && cnt !== 8'h00; i++) @(posedge sys_clk);
        if (i == 3000) begin
            n_mismatch++;
            report_and_stop;
        end
        hold <= 1'b1;
        @(posedge sys_clk);
        chk(8'(exp_q.size()), 8'h00, "runs missing");
        chk({7'h00, qst[1]}, 8'h01, "run flag");
    endtask
    // a count drop marks one run; compare with the oldest note
    always @(posedge sys_clk) begin
        if (!rst && cnt < prv) begin
            if (exp_q.size() == 0) chk(8'h00, 8'h01, "extra run");
            else begin
                e = exp_q.pop_front();
                chk({4'h0, lvl, ena}, {4'h0, e[3:0]}, "state");
                chk({6'h00, pin}, {6'h00, e[3:2] & e[1:0]}, "pin");
                chk(nxt, e[11:4], "next due");
            end
        end
        prv <= cnt;
    end
    initial begin
        void'($urandom(14));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(ilen, 8'h04, "in len");
        chk(olen, 8'h14, "out len");
        chk(olen_w, 8'h3c, "wide out len");
        chk(nxt, 8'h80, "next reset");
        $display("reset test done");
        // enables in every entry, end mark on the fifth
        for (int k = 0; k < 5; k++) wr(bs[k], (k == 4) ? 8'h45 : 8'(k + 1),
            16'(10 * (k + 1)));
        wv <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(cnt, 8'h05, "count");
        chk(last, 8'h45, "last seq");
        chk(nxt, 8'h81, "head due");
        chk({7'h00, qst[7]}, 8'h01, "end flag");
        plan;
        drain;
        $display("batch test done");
        for (int k = 0; k < 32; k++) wr({2'($urandom), 6'h30}, 8'(k + 1),
            tick + 16'h0001 + 16'($urandom % 64));
        wq <= 8'hee; // an extra entry offered while full
        repeat (3) @(posedge sys_clk);
        chk(cnt, 8'h20, "full count");
        chk({7'h00, rdy}, 8'h00, "full ready");
        chk(last, 8'h20, "refused seq");
        chk({7'h00, qst[0]}, 8'h01, "full flag");
        wv <= 1'b0;
        plan;
        drain;
        $display("fill test done");
        // lengths are never sent while running, so they stay fixed
        chk(ilen, 8'h04, "in len kept");
        chk(olen, 8'h14, "out len kept");
        $display("length test done");
        report_and_stop;
    end
endmodule // tos_scheduler_test
`default_nettype wire

/* tb/tos_ticker.sv */
// tos_ticker: head module microsecond ticker seen by the scheduler
// assumes sys_clk; DIV cycles stand for one microsecond to keep runs short
`timescale 1ns/100ps
`default_nettype none
module tos_ticker #(
    parameter int DIV = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hold,
    output logic [15:0] us_ticker
);
    int div_q; // cycles within the current microsecond
    // free running unless the bench freezes it to fill the queue
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_q <= 0;
            us_ticker <= 16'h0000;
        end else if (!hold) begin
            div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
            if (div_q == DIV - 1) us_ticker <= us_ticker + 16'h0001;
        end
    end
endmodule // tos_ticker
`default_nettype wire
